// ==== dv/ppm_mux_checker.sv ====
// concurrent checks on the pin function multiplexer ports
// bound into every ppm_mux instance, sees its ports only
`timescale 1ns/1ns
module ppm_mux_chk (
    input wire logic       clock,                         // clock
    input wire logic       rstn,                          // reset, low
    input wire logic       soft_reset,                    // soft reset
    input wire logic       cfg_we,                        // load
    input wire logic [7:0] port2_function_select_bits_in, // p2 select
    input wire logic [7:0] port3_function_select_bits_in, // p3 select
    input wire logic [7:0] analog_channel_enable_bits_in, // analog
    input wire logic       oscillator_resistor_select_in, // rosc
    input wire logic [7:0] port2_irq_flag_clear,          // flag clear
    input wire logic       debug_active,                  // debug on
    input wire logic       debug_data_oe,                 // debug drive
    input wire logic [7:0] pad1_oe,                       // p1 enables
    input wire logic [7:0] pad2_oe,                       // p2 enables
    input wire logic [7:0] pad3_oe,                       // p3 enables
    input wire logic [7:0] analog_connect,                // analog on
    input wire logic [7:0] port2_irq_flag_bits,           // flags
    input wire logic       oscillator_resistor_connect,   // rosc on
    input wire logic       port2_irq,                     // irq
    input wire logic       crystal_input_connect,         // xin on
    input wire logic       crystal_output_connect,        // crystal_output on
    input wire logic       serial0_force_3wire,           // s0 3-wire
    input wire logic       serial1_force_3wire            // s1 3-wire
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    logic ld;
    // soft reset beats a load in the same cycle
    assign ld = cfg_we && !soft_reset;
    a_reset_xtal_on: assert property ($rose(rstn) |->
        crystal_output_connect && pad1_oe == 8'h00) else $error("reset");
    a_soft_defaults: assert property (soft_reset |=>
        crystal_output_connect && !oscillator_resistor_connect)
        else $error("soft reset");
    a_debug_owns_p17: assert property (debug_active |->
        pad1_oe[7] == debug_data_oe && pad1_oe[6:4] == 3'h0)
        else $error("debug pin");
    a_analog_no_drive: assert property ((analog_connect &
        {pad3_oe[7:6], pad3_oe[0], pad2_oe[4:0]}) == 8'h00)
        else $error("analog drive");
    a_clk0_wins: assert property (ld |=> serial1_force_3wire ==
        ($past(port3_function_select_bits_in[0])
        && !$past(analog_channel_enable_bits_in[5]))) else $error("clk0");
    a_clk1_wins: assert property (ld |=> serial0_force_3wire ==
        $past(port3_function_select_bits_in[3])) else $error("clk1");
    a_rosc_follows: assert property (ld |=>
        oscillator_resistor_connect == $past(oscillator_resistor_select_in))
        else $error("rosc");
    a_xin_follows: assert property (ld |=>
        crystal_input_connect == $past(port2_function_select_bits_in[6]))
        else $error("xin");
    a_crystal_output_follows: assert property (ld |=>
        crystal_output_connect == $past(port2_function_select_bits_in[7]))
        else $error("crystal_output");
    a_irq_has_flag: assert property (port2_irq |->
        port2_irq_flag_bits != 8'h00) else $error("irq");
    a_flags_sticky: assert property (($past(port2_irq_flag_bits) &
        ~$past(port2_irq_flag_clear) & ~port2_irq_flag_bits) == 8'h00)
        else $error("flag lost");
endmodule // ppm_mux_chk
bind ppm_mux ppm_mux_chk chk_u (.*);

// ==== dv/ppm_pad_model.sv ====
// board side of one port: pads and the levels driven onto them
// an undriven pad shows the level the bench puts on it
`timescale 1ns/1ns
module ppm_pad_model #(
    parameter int unsigned W = 8   // pins in the port
) (
    input  wire logic [W-1:0] out, // pad data
    input  wire logic [W-1:0] oe,  // pad drive
    input  wire logic [W-1:0] ext, // external level
    output logic      [W-1:0] lvl  // level seen at the pad
);
    assign lvl = (oe & out) | (~oe & ext);
endmodule // ppm_pad_model

// ==== dv/tb_ppm_mux.sv ====
// self-checking bench for the pin function multiplexer
// control bits are plain ports, pads come from ppm_pad_model
`timescale 1ns/1ns
module tb_ppm_mux;
    logic clock, rstn, soft_reset, cfg_we, oscillator_resistor_select_in;
    logic debug_active, debug_data_out, debug_data_oe, crystal_output;
    logic [7:0] port1_direction_bits_in, port1_function_select_bits_in;
    logic [7:0] port2_direction_bits_in, port2_function_select_bits_in;
    logic [7:0] port3_direction_bits_in, port3_function_select_bits_in;
    logic [2:0] port4_direction_bits_in, port4_function_select_bits_in;
    logic [7:0] port2_pull_enable_bits_in, port2_irq_enable_bits_in;
    logic [7:0] port2_edge_select_bits_in, analog_channel_enable_bits_in;
    logic [7:0] port2_irq_flag_clear, port1_out, port2_output_bits;
    logic [2:0] port4_out, periph4_out, pad4_in, pad4_out, pad4_oe, port4_in;
    logic [7:0] periph1_out, periph2_out, serial_out, serial_oe, serial_in;
    logic [7:0] pad1_in, pad2_in, pad3_in, pad1_out, pad1_oe, pad2_out;
    logic [7:0] pad2_oe, pad3_out, pad3_oe, pad2_pull_en, analog_connect;
    logic [7:0] port1_in, port2_input_bits, port3_in, periph1_in, periph2_in;
    logic [7:0] port2_irq_flag_bits, port3_out, e1, e2, e3;
    logic [2:0] periph4_in, e4;
    logic debug_data_in, oscillator_resistor_connect, crystal_input_connect;
    logic crystal_output_connect, serial0_force_3wire, serial1_force_3wire;
    logic port2_irq;
    int bad_count, num_checks;
    ppm_mux dut_u (.*);
    ppm_pad_model m1_u (.out(pad1_out), .oe(pad1_oe), .ext(e1), .lvl(pad1_in));
    ppm_pad_model m2_u (.out(pad2_out), .oe(pad2_oe), .ext(e2), .lvl(pad2_in));
    ppm_pad_model m3_u (.out(pad3_out), .oe(pad3_oe), .ext(e3), .lvl(pad3_in));
    ppm_pad_model #(.W(3)) m4_u (.out(pad4_out), .oe(pad4_oe), .ext(e4),
        .lvl(pad4_in));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one load pulse; an extra edge keeps cfg_we from toggling twice
    task automatic ld();
        cfg_we = 1'b1;
        @(negedge clock);
        cfg_we = 1'b0;
        @(negedge clock);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        #(50 * 400);
        bad_count++;
        end_of_test();
    end
    initial begin
        {rstn, soft_reset, cfg_we, oscillator_resistor_select_in} = 4'h0;
        {debug_active, debug_data_out, debug_data_oe, crystal_output} = 4'h1;
        {port1_direction_bits_in, port1_function_select_bits_in} = 16'h0;
        {port2_direction_bits_in, port2_function_select_bits_in} = 16'h0;
        {port3_direction_bits_in, port3_function_select_bits_in} = 16'h0;
        {port4_direction_bits_in, port4_function_select_bits_in} = 6'h0;
        {port2_pull_enable_bits_in, port2_irq_enable_bits_in} = 16'h0;
        {port2_edge_select_bits_in, analog_channel_enable_bits_in} = 16'h0;
        {port2_irq_flag_clear, port1_out, port2_output_bits} = 24'h0;
        {port3_out, periph1_out, periph2_out, serial_out, serial_oe} = 40'h0;
        {port4_out, periph4_out, e4, e1, e3} = 25'h0;
        e2 = 8'hc0;
        repeat (4) @(posedge clock);
        @(negedge clock);
        rstn = 1'b1;
        chk(pad2_oe, 8'h80);
        chk(pad1_oe | pad3_oe, 8'h00);
        chk(pad2_out & 8'h80, 8'h80);
        chk({7'h0, crystal_input_connect}, 8'h01);
        port1_direction_bits_in = 8'h0f;
        port1_out = 8'ha5;
        e1 = 8'h3c;
        ld();
        chk(pad1_oe, 8'h0f);
        chk(pad1_out & 8'h0f, 8'h05);
        chk(port1_in, 8'h35);
        chk(pad2_oe, 8'h00);
        chk(port2_input_bits, 8'hc0);
        chk({7'h0, crystal_input_connect}, 8'h00);
        {port4_function_select_bits_in, port4_direction_bits_in} = 6'h3d;
        {periph4_out, e4} = 6'h1a;
        port2_function_select_bits_in = 8'h1f;
        port2_direction_bits_in = 8'h1f;
        periph2_out = 8'h15;
        port1_function_select_bits_in = 8'hf0;
        ld();
        chk(8'(pad4_oe), 8'h05);
        chk(8'(pad4_out & pad4_oe), 8'h01);
        chk(8'(periph4_in[1]), 8'h01);
        chk(pad2_out & 8'h1f, 8'h15);
        chk(periph1_in, 8'h30);
        chk(8'(port4_in), 8'h03);
        port1_direction_bits_in = 8'hff;
        port1_out = 8'h00;
        {debug_active, debug_data_out, debug_data_oe} = 3'h7;
        ld();
        chk(pad1_oe, 8'h8f);
        chk(pad1_out & 8'h80, 8'h80);
        debug_data_oe = 1'b0;
        e1 = 8'h80;
        @(negedge clock);
        chk({7'h0, debug_data_in}, 8'h01);
        debug_active = 1'b0;
        @(negedge clock);
        chk(pad1_oe, 8'hff);
        analog_channel_enable_bits_in = 8'hff;
        port2_function_select_bits_in = 8'h00;
        port2_direction_bits_in = 8'hff;
        port3_direction_bits_in = 8'hff;
        port2_pull_enable_bits_in = 8'hff;
        e2 = 8'hff;
        ld();
        chk(analog_connect, 8'hff);
        chk(pad2_oe, 8'he0);
        chk(pad3_oe & 8'hc1, 8'h00);
        chk(pad2_pull_en, 8'he0);
        chk(port2_input_bits & 8'h1f, 8'h00);
        analog_channel_enable_bits_in = 8'h00;
        {port3_direction_bits_in, port3_function_select_bits_in} = 16'h3f;
        {serial_oe, serial_out} = 16'h0a3f;
        e3 = 8'hf0;
        ld();
        chk(pad3_oe & 8'h3f, 8'h0a);
        chk(pad3_out & 8'h0a, 8'h0a);
        chk(serial_in, 8'h3a);
        chk(port3_in, 8'hfa);
        chk(8'({serial1_force_3wire, serial0_force_3wire}), 8'h03);
        port3_function_select_bits_in = 8'h01;
        ld();
        chk(8'({serial1_force_3wire, serial0_force_3wire}), 8'h02);
        port3_function_select_bits_in = 8'h08;
        ld();
        chk(8'({serial1_force_3wire, serial0_force_3wire}), 8'h01);
        {port2_function_select_bits_in, port2_direction_bits_in} = 16'h2020;
        port2_output_bits = 8'hff;
        ld();
        chk(pad2_oe & 8'h20, 8'h20);
        chk(pad2_out & 8'h20, 8'h00);
        port2_direction_bits_in = 8'h00;
        ld();
        chk(pad2_oe & 8'h20, 8'h00);
        port2_direction_bits_in = 8'h20;
        oscillator_resistor_select_in = 1'b1;
        ld();
        chk({7'h0, oscillator_resistor_connect}, 8'h01);
        chk(pad2_oe & 8'h20, 8'h00);
        soft_reset = 1'b1;
        @(negedge clock);
        soft_reset = 1'b0;
        @(negedge clock);
        chk(pad2_oe, 8'h80);
        chk({7'h0, oscillator_resistor_connect}, 8'h00);
        {port2_function_select_bits_in, port2_direction_bits_in} = 16'h0;
        oscillator_resistor_select_in = 1'b0;
        {port2_irq_enable_bits_in, port2_edge_select_bits_in} = 16'h0102;
        e2 = 8'h02;
        ld();
        port2_irq_flag_clear = 8'hff;
        @(negedge clock);
        port2_irq_flag_clear = 8'h00;
        @(negedge clock);
        chk(port2_irq_flag_bits, 8'h00);
        e2 = 8'h01;
        repeat (3) @(negedge clock);
        chk(port2_irq_flag_bits, 8'h03);
        chk({7'h0, port2_irq}, 8'h01);
        port2_irq_flag_clear = 8'h01;
        @(negedge clock);
        port2_irq_flag_clear = 8'h00;
        @(negedge clock);
        chk(port2_irq_flag_bits, 8'h02);
        chk({7'h0, port2_irq}, 8'h00);
        // falling edge on pin 1 in the same cycle as its clear
        e2 = 8'h03;
        @(negedge clock);
        e2 = 8'h01;
        port2_irq_flag_clear = 8'h02;
        @(negedge clock);
        port2_irq_flag_clear = 8'h00;
        @(negedge clock);
        chk(port2_irq_flag_bits, 8'h02);
        end_of_test();
    end
endmodule // tb_ppm_mux

// ==== hw/ppm_edge_flags.sv ====
`timescale 1ns/1ns
// port 2 edge detect and sticky interrupt flags
// assumes pad inputs already synchronous to clock
module ppm_edge_flags #(
    parameter int unsigned W = 8
) (
    input  wire logic         clock,      // system clock
    input  wire logic         rstn,       // async reset, active low
    input  wire logic [W-1:0] pin_in,     // gated pad input levels
    input  wire logic [W-1:0] edge_sel,   // 0 rising, 1 falling
    input  wire logic [W-1:0] irq_en,     // per pin interrupt enable
    input  wire logic [W-1:0] flag_clr,   // one-cycle clear pulses
    output logic      [W-1:0] flag_r,     // sticky flags
    output logic              irq         // interrupt request
);
    logic [W-1:0] prev_r;
    logic [W-1:0] hit;
    logic         armed_r;

    if (W == 0) begin : g_bad_w
        $error("ppm_edge_flags: W must be at least 1");
    end

    // prev_r holds no real pin level until one edge has passed; without
    // armed_r a pin that is high at reset would raise a false flag
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prev_r  <= '0;
            armed_r <= 1'b0;
        end else begin
            prev_r  <= pin_in;
            armed_r <= 1'b1;
        end
    end

    generate
        for (genvar i = 0; i < W; i++) begin : g_edge
            // chosen edge of pin i
            assign hit[i] = armed_r
                          & (edge_sel[i] ? (prev_r[i] & ~pin_in[i])
                                         : (~prev_r[i] & pin_in[i]));
            // set wins over a clear in the same cycle
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    flag_r[i] <= 1'b0;
                end else if (hit[i]) begin
                    flag_r[i] <= 1'b1;
                end else if (flag_clr[i]) begin
                    flag_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq = |(flag_r & irq_en);
endmodule // ppm_edge_flags

// ==== hw/ppm_mux.sv ====
`timescale 1ns/1ns
// pin function multiplexer for ports 1..4 (port 4 pins 0..2)
// assumes control bits come from a cpu-side register block
module ppm_mux (
    input  wire logic       clock,                 // system clock
    input  wire logic       rstn,                  // async reset, low
    input  wire logic       soft_reset,            // sync soft reset
    input  wire logic       cfg_we,                // load control bits
    input  wire logic [7:0] port1_direction_bits_in,      // new dir p1
    input  wire logic [7:0] port1_function_select_bits_in,// new sel p1
    input  wire logic [7:0] port2_direction_bits_in,      // new dir p2
    input  wire logic [7:0] port2_function_select_bits_in,// new sel p2
    input  wire logic [7:0] port3_direction_bits_in,      // new dir p3
    input  wire logic [7:0] port3_function_select_bits_in,// new sel p3
    input  wire logic [2:0] port4_direction_bits_in,      // new dir p4
    input  wire logic [2:0] port4_function_select_bits_in,// new sel p4
    input  wire logic [7:0] port2_pull_enable_bits_in,    // new pull
    input  wire logic [7:0] port2_irq_enable_bits_in,     // new ie
    input  wire logic [7:0] port2_edge_select_bits_in,    // new ies
    input  wire logic [7:0] analog_channel_enable_bits_in,// new ae
    input  wire logic       oscillator_resistor_select_in,// new rsel
    input  wire logic [7:0] port2_irq_flag_clear,  // flag clear pulses
    input  wire logic [7:0] port1_out,             // port 1 out bits
    input  wire logic [7:0] port2_output_bits,     // port 2 out bits
    input  wire logic [7:0] port3_out,             // port 3 out bits
    input  wire logic [2:0] port4_out,             // port 4 out bits
    input  wire logic       debug_active,          // 4-wire debug on
    input  wire logic       debug_data_out,        // debug data to pad
    input  wire logic       debug_data_oe,         // debug data drive
    input  wire logic [7:0] periph1_out,           // peripheral outs p1
    input  wire logic [7:0] periph2_out,           // peripheral outs p2
    input  wire logic [7:0] serial_out,            // serial outs p3
    input  wire logic [7:0] serial_oe,             // serial dir p3
    input  wire logic [2:0] periph4_out,           // timer b outs p4
    input  wire logic       crystal_output,        // oscillator drive
    input  wire logic [7:0] pad1_in,               // pad levels p1
    input  wire logic [7:0] pad2_in,               // pad levels p2
    input  wire logic [7:0] pad3_in,               // pad levels p3
    input  wire logic [2:0] pad4_in,               // pad levels p4
    output logic      [7:0] pad1_out,              // pad data p1
    output logic      [7:0] pad1_oe,               // pad enable p1
    output logic      [7:0] pad2_out,              // pad data p2
    output logic      [7:0] pad2_oe,               // pad enable p2
    output logic      [7:0] pad3_out,              // pad data p3
    output logic      [7:0] pad3_oe,               // pad enable p3
    output logic      [2:0] pad4_out,              // pad data p4
    output logic      [2:0] pad4_oe,               // pad enable p4
    output logic      [7:0] pad2_pull_en,          // pull resistor on
    output logic      [7:0] analog_connect,        // analog switch on
    output logic      [7:0] port1_in,              // port 1 in bits
    output logic      [7:0] port2_input_bits,      // port 2 in bits
    output logic      [7:0] port3_in,              // port 3 in bits
    output logic      [2:0] port4_in,              // port 4 in bits
    output logic      [7:0] periph1_in,            // capture/clk p1
    output logic      [7:0] periph2_in,            // capture/clk p2
    output logic      [7:0] serial_in,             // serial ins p3
    output logic      [2:0] periph4_in,            // capture p4
    output logic            debug_data_in,         // pad 1.7 to debug
    output logic            oscillator_resistor_connect, // rosc on
    output logic            crystal_input_connect, // xin on
    output logic            crystal_output_connect,// crystal_output on
    output logic            serial0_force_3wire,   // slave enable lost
    output logic            serial1_force_3wire,   // slave enable lost
    output logic      [7:0] port2_irq_flag_bits,   // sticky flags
    output logic            port2_irq              // interrupt request
);
    localparam int unsigned W = ppm_pkg::PORT_W;

    // the pin ports are fixed at one byte; another port width
    // in the package cannot be served by this port list
    if (W != $bits(port1_out)) begin : g_bad_width
        $error("ppm_mux: port width constant does not match the ports");
    end

    logic [7:0] p1_dir_r;
    logic [7:0] p1_sel_r;
    logic [7:0] p2_dir_r;
    logic [7:0] p2_sel_r;
    logic [7:0] p3_dir_r;
    logic [7:0] p3_sel_r;
    logic [2:0] p4_dir_r;
    logic [2:0] p4_sel_r;
    logic [7:0] p2_ren_r;
    logic [7:0] p2_ie_r;
    logic [7:0] p2_ies_r;
    logic [7:0] ae_r;
    logic       rsel_r;
    // gated port 2 input, also feeds edge detect so a crystal
    // or analog pin reads 0 there; only its switch into or out of that use can raise a flag
    logic [7:0] p2_gate_in;

    // control bits: both resets return to defaults
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            p1_dir_r <= ppm_pkg::DIR_RST;
            p1_sel_r <= ppm_pkg::SEL_RST;
            p2_dir_r <= ppm_pkg::DIR_RST;
            p2_sel_r <= ppm_pkg::SEL2_RST;
            p3_dir_r <= ppm_pkg::DIR_RST;
            p3_sel_r <= ppm_pkg::SEL_RST;
            p4_dir_r <= '0;
            p4_sel_r <= '0;
            p2_ren_r <= '0;
            p2_ie_r  <= '0;
            p2_ies_r <= '0;
            ae_r     <= '0;
            rsel_r   <= 1'b0;
        end else if (soft_reset) begin
            p1_dir_r <= ppm_pkg::DIR_RST;
            p1_sel_r <= ppm_pkg::SEL_RST;
            p2_dir_r <= ppm_pkg::DIR_RST;
            p2_sel_r <= ppm_pkg::SEL2_RST;
            p3_dir_r <= ppm_pkg::DIR_RST;
            p3_sel_r <= ppm_pkg::SEL_RST;
            p4_dir_r <= '0;
            p4_sel_r <= '0;
            p2_ren_r <= '0;
            p2_ie_r  <= '0;
            p2_ies_r <= '0;
            ae_r     <= '0;
            rsel_r   <= 1'b0;
        end else if (cfg_we) begin
            p1_dir_r <= port1_direction_bits_in;
            p1_sel_r <= port1_function_select_bits_in;
            p2_dir_r <= port2_direction_bits_in;
            p2_sel_r <= port2_function_select_bits_in;
            p3_dir_r <= port3_direction_bits_in;
            p3_sel_r <= port3_function_select_bits_in;
            p4_dir_r <= port4_direction_bits_in;
            p4_sel_r <= port4_function_select_bits_in;
            p2_ren_r <= port2_pull_enable_bits_in;
            p2_ie_r  <= port2_irq_enable_bits_in;
            p2_ies_r <= port2_edge_select_bits_in;
            ae_r     <= analog_channel_enable_bits_in;
            rsel_r   <= oscillator_resistor_select_in;
        end
    end

    // analog bit map: p2.0-p2.4 are a0-a4, p3.0 a5, p3.6 a6, p3.7 a7
    logic [7:0] p2_ae, p3_ae;
    assign p2_ae = {3'b000, ae_r[4:0]};
    assign p3_ae = {ae_r[7:6], 5'b00000, ae_r[5]};
    assign analog_connect = ae_r;

    // port 1: pins 4..7 yield to the debug port
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pad1_out[i]   = p1_sel_r[i] ? periph1_out[i] : port1_out[i];
            pad1_oe[i]    = p1_dir_r[i];
            port1_in[i]   = pad1_in[i];
            periph1_in[i] = p1_sel_r[i] & ~p1_dir_r[i] & pad1_in[i];
            if (debug_active && i >= ppm_pkg::P1_DBG_LO) begin
                pad1_oe[i]    = 1'b0;
                pad1_out[i]   = 1'b0;
                port1_in[i]   = 1'b0;
                periph1_in[i] = 1'b0;
            end
        end
        if (debug_active) begin
            pad1_out[ppm_pkg::P1_DBG_PIN] = debug_data_out;
            pad1_oe[ppm_pkg::P1_DBG_PIN]  = debug_data_oe;
        end
    end
    // only pin 7 data is routed here; other debug pins are input-only
    assign debug_data_in = debug_active & pad1_in[ppm_pkg::P1_DBG_PIN];

    // port 2: analog, resistor and crystal overrides
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pad2_out[i]   = p2_sel_r[i] ? periph2_out[i]
                                        : port2_output_bits[i];
            pad2_oe[i]    = p2_dir_r[i];
            p2_gate_in[i] = pad2_in[i];
            periph2_in[i] = p2_sel_r[i] & ~p2_dir_r[i] & pad2_in[i];
            if (p2_ae[i]) begin
                pad2_oe[i]    = 1'b0;
                p2_gate_in[i] = 1'b0;
                periph2_in[i] = 1'b0;
            end
        end
        // resistor pin: selected output is a ground driver
        if (rsel_r) begin
            pad2_oe[ppm_pkg::P2_ROSC_PIN]    = 1'b0;
            p2_gate_in[ppm_pkg::P2_ROSC_PIN] = 1'b0;
        end else if (p2_sel_r[ppm_pkg::P2_ROSC_PIN]) begin
            pad2_out[ppm_pkg::P2_ROSC_PIN] = 1'b0;
        end
        periph2_in[ppm_pkg::P2_ROSC_PIN] = 1'b0;
        if (p2_sel_r[ppm_pkg::P2_XIN_PIN]) begin
            pad2_oe[ppm_pkg::P2_XIN_PIN]    = 1'b0;
            p2_gate_in[ppm_pkg::P2_XIN_PIN] = 1'b0;
        end
        periph2_in[ppm_pkg::P2_XIN_PIN] = 1'b0;
        if (p2_sel_r[ppm_pkg::P2_CRYSTAL_OUTPUT_PIN]) begin
            pad2_out[ppm_pkg::P2_CRYSTAL_OUTPUT_PIN]  = crystal_output;
            pad2_oe[ppm_pkg::P2_CRYSTAL_OUTPUT_PIN]   = 1'b1;
            p2_gate_in[ppm_pkg::P2_CRYSTAL_OUTPUT_PIN] = 1'b0;
        end
        periph2_in[ppm_pkg::P2_CRYSTAL_OUTPUT_PIN] = 1'b0;
    end
    assign port2_input_bits = p2_gate_in;
    assign pad2_pull_en = p2_ren_r & ~p2_ae;
    assign oscillator_resistor_connect = rsel_r;
    assign crystal_input_connect  = p2_sel_r[ppm_pkg::P2_XIN_PIN];
    assign crystal_output_connect = p2_sel_r[ppm_pkg::P2_CRYSTAL_OUTPUT_PIN];

    // port 3: serial pins take direction from the serial module
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (p3_sel_r[i]) begin
                pad3_out[i] = serial_out[i];
                pad3_oe[i]  = serial_oe[i];
            end else begin
                pad3_out[i] = port3_out[i];
                pad3_oe[i]  = p3_dir_r[i];
            end
            port3_in[i]  = pad3_in[i];
            serial_in[i] = p3_sel_r[i] & pad3_in[i];
            if (p3_ae[i]) begin
                pad3_oe[i]   = 1'b0;
                port3_in[i]  = 1'b0;
                serial_in[i] = 1'b0;
            end
        end
    end
    // a shared pin in serial use serves the clock function, except pin 0 while its analog bit a5 is set
    assign serial1_force_3wire = p3_sel_r[ppm_pkg::P3_CLK0_PIN]
                               & ~p3_ae[ppm_pkg::P3_CLK0_PIN];
    assign serial0_force_3wire = p3_sel_r[ppm_pkg::P3_CLK1_PIN];

    // port 4 pins 0..2: timer b
    always_comb begin
        for (int i = 0; i < ppm_pkg::P4_USED_W; i++) begin
            pad4_out[i]   = p4_sel_r[i] ? periph4_out[i] : port4_out[i];
            pad4_oe[i]    = p4_dir_r[i];
            port4_in[i]   = pad4_in[i];
            periph4_in[i] = p4_sel_r[i] & ~p4_dir_r[i] & pad4_in[i];
        end
    end

    ppm_edge_flags #(
        .W (W)
    ) u_flags (
        .clock    (clock),
        .rstn     (rstn),
        .pin_in   (p2_gate_in),
        .edge_sel (p2_ies_r),
        .irq_en   (p2_ie_r),
        .flag_clr (port2_irq_flag_clear),
        .flag_r   (port2_irq_flag_bits),
        .irq      (port2_irq)
    );
endmodule // ppm_mux

// ==== hw/ppm_pkg.sv ====
// constants for the port pin function multiplexer
// assumes a single system clock and plain-port control bits
// Notes on behaviour
// - after reset every muxed pin is plain port I/O, except the crystal pins, which start in oscillator function.
// - with the select bit clear the pin is port I/O and its direction bit picks input (0) or output (1).
// - with the select bit set the pad is driven by the peripheral signal, the direction bit picks peripheral output (1) or input (0).
// - while the 4-wire debug port is active, port 1 pin 7 carries debug data whatever its direction and select bits.
// - pins with debug access give the debug port priority; port and timer functions work only while it is idle.
// - a set analog-enable bit connects the pin to its channel and turns off output driver and input buffer.
// - on serial-interface pins the serial module, not the direction bit, decides the pad direction.
// - on the pin shared by serial0 clock and serial1 slave enable the clock wins and forces serial1 to 3-wire.
// - on the pin shared by serial1 clock and serial0 slave enable the clock wins and forces serial0 to 3-wire.
// - port 2 pin 5 goes to the oscillator resistor when its select is 1, else select with direction 1 drives ground and direction 0 does nothing.
// - port 2 pin 6 is crystal input when selected, whatever the direction, and port I/O otherwise.
// - port 2 pin 7 drives crystal output while selected, as after reset, and is port I/O once cleared.
package ppm_pkg;
    localparam int unsigned PORT_W      = 8;
    localparam logic [7:0] DIR_RST      = 8'h00;
    localparam logic [7:0] SEL_RST      = 8'h00;
    localparam logic [7:0] SEL2_RST     = 8'hc0;
    localparam int unsigned P1_DBG_PIN  = 7;
    localparam int unsigned P1_DBG_LO   = 4;
    localparam int unsigned P2_ROSC_PIN = 5;
    localparam int unsigned P2_XIN_PIN  = 6;
    localparam int unsigned P2_CRYSTAL_OUTPUT_PIN = 7;
    localparam int unsigned P3_CLK0_PIN = 0;
    localparam int unsigned P3_CLK1_PIN = 3;
    localparam int unsigned P4_USED_W   = 3;
endpackage
